// *** srls_defs.vh ***
// srls_defs.vh: register map, fields and reset values of the latch input
// selection block; plain definitions, included by bare name
`ifndef SRLS_DEFS_VH
`define SRLS_DEFS_VH

// ---------------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------------
`define SRLS_ADDR_W 2
`define SRLS_OFF_CTRL 2'h0
`define SRLS_OFF_ENA 2'h1
`define SRLS_OFF_STAT 2'h2

// ---------------------------------------------------------------------
// latch_control_main fields
// ---------------------------------------------------------------------
`define SRLS_CTRL_LEN 7
`define SRLS_CTRL_DIV_HI 6
`define SRLS_CTRL_DIV_LO 4
`define SRLS_CTRL_QEN 3
`define SRLS_CTRL_NQEN 2
`define SRLS_CTRL_PS 1
`define SRLS_CTRL_PR 0
`define SRLS_CTRL_RST 8'h00

// ---------------------------------------------------------------------
// latch_source_enables fields
// ---------------------------------------------------------------------
`define SRLS_EN_PIN_SET 7
`define SRLS_EN_CLK_SET 6
`define SRLS_EN_CMP2_SET 5
`define SRLS_EN_CMP1_SET 4
`define SRLS_EN_PIN_RST 3
`define SRLS_EN_CLK_RST 2
`define SRLS_EN_CMP2_RST 1
`define SRLS_EN_CMP1_RST 0
`define SRLS_ENA_RST 8'h00

// ---------------------------------------------------------------------
// divider
// ---------------------------------------------------------------------
`define SRLS_DIV_CNT_W 9

`endif

// *** srls_divider.v ***
// srls_divider.v: periodic one-cycle pulse every 2^(code+2) cycles
// assumes: code from a register on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "srls_defs.vh"
module srls_divider (
  input wire core_clk,
  input wire arst_n,
  input wire [2:0] div_code,
  output reg pulse
);
  reg [`SRLS_DIV_CNT_W-1:0] cnt_q;
  wire [`SRLS_DIV_CNT_W-1:0] last_w;
  // terminal count = 2^(code+2) - 1
  // four-bit shift amount so codes 6 and 7 do not wrap
  assign last_w = ({{(`SRLS_DIV_CNT_W-1){1'b0}}, 1'b1}
    << ({1'b0, div_code} + 4'h2))
    - {{(`SRLS_DIV_CNT_W-1){1'b0}}, 1'b1};
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= {`SRLS_DIV_CNT_W{1'b0}};
      pulse <= 1'b0;
    end else begin
      if (cnt_q >= last_w) begin
        cnt_q <= {`SRLS_DIV_CNT_W{1'b0}};
        pulse <= 1'b1;
      end else begin
        cnt_q <= cnt_q + {{(`SRLS_DIV_CNT_W-1){1'b0}}, 1'b1};
        pulse <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** srls_partner.sv ***
// srls_partner.sv: latch pin and two comparator levels
// assumes: bench sets wanted levels; outputs lag by DLY ns
`timescale 1ns/1ps
`default_nettype none
module srls_partner #(parameter int DLY = 1) (
  input wire logic [2:0] lvl,
  output logic latch_input_pin,
  output logic comparator_two,
  output logic comparator_one
);
  // levels move off the clock edge, like analog outputs
  assign #(DLY) {latch_input_pin, comparator_two, comparator_one} = lvl;
endmodule
`default_nettype wire

// *** srls_props.sv ***
// srls_props.sv: port checker for srls_top
// assumes: bound into srls_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module srls_props (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic latch_input_pin,
  input wire logic comparator_one,
  input wire logic comparator_two,
  input wire logic latch_set,
  input wire logic latch_reset
);
  // ----
  // shadow of enables, code, pulse spacing
  // ----
  logic [7:0] ena_q;
  logic [2:0] code_q;
  logic [9:0] cnt_q;
  logic vld_q;
  logic soft_set_s;
  logic soft_rst_s;
  // software pulse writes also drive the latch inputs
  assign soft_set_s = reg_wr && reg_addr == 2'h0 && reg_wdata[1];
  assign soft_rst_s = reg_wr && reg_addr == 2'h0 && reg_wdata[0];
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ena_q <= 8'h00;
      code_q <= 3'h0;
      cnt_q <= 10'h000;
      vld_q <= 1'b0;
    end else begin
      cnt_q <= latch_set ? 10'h000 : cnt_q + 10'h001;
      vld_q <= latch_set | (vld_q & !reg_wr);
      if (reg_wr && reg_addr == 2'h1)
        ena_q <= reg_wdata;
      if (reg_wr && reg_addr == 2'h0)
        code_q <= reg_wdata[6:4];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_hi(x);
    x [*7];
  endsequence
  chk_pin_set: assert property (
    s_hi(ena_q[7] & latch_input_pin) |-> latch_set) else $error("no set");
  chk_cmp1_set: assert property (
    s_hi(ena_q[4] & comparator_one) |-> latch_set) else $error("no set");
  chk_pin_rst: assert property (
    s_hi(ena_q[3] & latch_input_pin) |-> latch_reset) else $error("no rst");
  chk_cmp2_rst: assert property (
    s_hi(ena_q[1] & comparator_two) |-> latch_reset) else $error("no rst");
  chk_set_idle: assert property (
    (ena_q[7:4] == 4'h0 && !soft_set_s) [*3] |-> !latch_set)
    else $error("stray set");
  chk_rst_idle: assert property (
    (ena_q[3:0] == 4'h0 && !soft_rst_s) [*3] |-> !latch_reset)
    else $error("stray rst");
  chk_pulse_width: assert property (
    ena_q == 8'h40 && latch_set |=> !latch_set) else $error("wide pulse");
  chk_pulse_period: assert property (
    ena_q == 8'h40 && latch_set && vld_q |->
    cnt_q == (10'h004 << code_q) - 10'h001) else $error("bad period");
endmodule
bind srls_top srls_props chk_u (.core_clk, .arst_n, .reg_addr, .reg_wdata,
  .reg_wr, .latch_input_pin, .comparator_one, .comparator_two, .latch_set,
  .latch_reset);
`default_nettype wire

// *** srls_sync.v ***
// srls_sync.v: three-stage synchroniser with agreement filter
// assumes: input from outside the core_clk domain
`timescale 1ns/1ps
`default_nettype none
module srls_sync (
  input wire core_clk,
  input wire arst_n,
  input wire async_in,
  output reg sync_out
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // change counts once second and third agree
      if (s2_q == s3_q) begin
        sync_out <= s3_q;
      end
    end
  end
endmodule
`default_nettype wire

// *** srls_top.v ***
// srls_top.v: set and reset source selection for the set/reset latch
// assumes: comparator outputs and latch pin are asynchronous levels;
// register port is a same-clock master with one-cycle strobes
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "srls_defs.vh"
module srls_top (
  input wire core_clk,
  input wire arst_n,
  input wire [`SRLS_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire latch_input_pin,
  input wire comparator_one,
  input wire comparator_two,
  output reg latch_set,
  output reg latch_reset
);
  // -------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------
  reg [6:2] ctrl_q;
  reg [7:0] ena_q;
  reg soft_set_q;
  reg soft_rst_q;
  wire pin_s;
  wire cmp1_s;
  wire cmp2_s;
  wire divided_pulse_clock;
  reg set_d;
  reg rst_d;
  reg latch_enable_bit;

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= 5'h00;
      latch_enable_bit <= 1'b0;
      ena_q <= `SRLS_ENA_RST;
      soft_set_q <= 1'b0;
      soft_rst_q <= 1'b0;
    end else begin
      soft_set_q <= 1'b0;
      soft_rst_q <= 1'b0;
      if (reg_wr && reg_addr == `SRLS_OFF_CTRL) begin
        latch_enable_bit <= reg_wdata[`SRLS_CTRL_LEN];
        ctrl_q <= reg_wdata[6:2];
        soft_set_q <= reg_wdata[`SRLS_CTRL_PS];
        soft_rst_q <= reg_wdata[`SRLS_CTRL_PR];
      end
      if (reg_wr && reg_addr == `SRLS_OFF_ENA) begin
        ena_q <= reg_wdata;
      end
    end
  end

  // -------------------------------------------------------------------
  // read port
  // -------------------------------------------------------------------
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `SRLS_OFF_CTRL: reg_rdata <= {latch_enable_bit, ctrl_q, 2'h0};
        `SRLS_OFF_ENA: reg_rdata <= ena_q;
        `SRLS_OFF_STAT: reg_rdata <= {3'h0, pin_s, cmp1_s, cmp2_s,
          latch_set, latch_reset};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // -------------------------------------------------------------------
  // input synchronisers and divider
  // -------------------------------------------------------------------
  srls_sync u_sync_pin (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .async_in(latch_input_pin),
    .sync_out(pin_s)
  );
  srls_sync u_sync_c1 (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .async_in(comparator_one),
    .sync_out(cmp1_s)
  );
  srls_sync u_sync_c2 (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .async_in(comparator_two),
    .sync_out(cmp2_s)
  );
  srls_divider u_div (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .div_code(ctrl_q[`SRLS_CTRL_DIV_HI:`SRLS_CTRL_DIV_LO]),
    .pulse(divided_pulse_clock)
  );

  // -------------------------------------------------------------------
  // source gating
  // -------------------------------------------------------------------
  always @* begin
    set_d = soft_set_q;
    set_d = set_d | (ena_q[`SRLS_EN_CLK_SET] & divided_pulse_clock);
    set_d = set_d | (ena_q[`SRLS_EN_CMP1_SET] & cmp1_s);
    set_d = set_d | (ena_q[`SRLS_EN_PIN_SET] & pin_s);
    set_d = set_d | (ena_q[`SRLS_EN_CMP2_SET] & cmp2_s);
    rst_d = soft_rst_q;
    rst_d = rst_d | (ena_q[`SRLS_EN_PIN_RST] & pin_s);
    rst_d = rst_d | (ena_q[`SRLS_EN_CLK_RST] & divided_pulse_clock);
    rst_d = rst_d | (ena_q[`SRLS_EN_CMP2_RST] & cmp2_s);
    rst_d = rst_d | (ena_q[`SRLS_EN_CMP1_RST] & cmp1_s);
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      latch_set <= 1'b0;
      latch_reset <= 1'b0;
    end else begin
      latch_set <= set_d;
      latch_reset <= rst_d;
    end
  end
endmodule
`default_nettype wire

// *** srls_top_tb.sv ***
// srls_top_tb.sv: self-checking bench for srls_top
// assumes: design, partner and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module srls_top_tb;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [2:0] lvl = 3'h0;
  wire [7:0] reg_rdata;
  wire latch_input_pin, comparator_one, comparator_two;
  wire latch_set, latch_reset;
  int failures = 0;
  int n_checks = 0;
  always #2 core_clk = ~core_clk;
  srls_top dut_u (.core_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .latch_input_pin, .comparator_one,
    .comparator_two, .latch_set, .latch_reset);
  srls_partner far_u (.lvl, .latch_input_pin, .comparator_two,
    .comparator_one);
  // ----
  // bus and compare tasks
  // ----
  task automatic chk(input string nm, input logic [9:0] e, g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk("rdata", 10'(e), 10'(reg_rdata));
    @(posedge core_clk);
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_regs;
    rd(2'h1, 8'h00);
    wr(2'h1, 8'ha5);
    wr(2'h3, 8'hff);
    rd(2'h1, 8'ha5);
    rd(2'h3, 8'h00);
  endtask
  task automatic t_soft;
    wr(2'h1, 8'h00);
    wr(2'h0, 8'h03);
    @(negedge core_clk);
    chk("soft set", 10'h001, 10'(latch_set));
    chk("soft reset", 10'h001, 10'(latch_reset));
    @(negedge core_clk);
    chk("soft set end", 10'h000, 10'(latch_set));
    chk("soft reset end", 10'h000, 10'(latch_reset));
    @(posedge core_clk);
    rd(2'h0, 8'h00);
    lvl <= 3'h7;
    repeat (9) @(posedge core_clk);
    rd(2'h2, 8'h1c);
    lvl <= 3'h0;
    repeat (9) @(posedge core_clk);
    rd(2'h2, 8'h00);
  endtask
  task automatic t_src;
    int k;
    for (int b = 0; b < 8; b++) begin
      k = (b % 4 == 3) ? 2 : b % 4;
      if (b % 4 != 2) begin
        wr(2'h1, 8'(1 << b));
        for (int s = 0; s < 3; s++) begin
          lvl <= 3'(1 << s);
          repeat (9) @(posedge core_clk);
          chk("set", 10'(b > 3 && s == k), 10'(latch_set));
          chk("reset", 10'(b < 4 && s == k), 10'(latch_reset));
          lvl <= 3'h0;
          repeat (9) @(posedge core_clk);
        end
      end
    end
  endtask
  task automatic per(input bit r, output int p);
    for (p = 0; p < 600 && !(r ? latch_reset : latch_set); p++)
      @(negedge core_clk);
    if (p == 600) begin
      failures++;
      wrap_up;
    end
    @(negedge core_clk);
    chk("width", 10'h000, 10'(r ? latch_reset : latch_set));
    for (p = 1; p < 600 && !(r ? latch_reset : latch_set); p++)
      @(negedge core_clk);
    if (p == 600) begin
      failures++;
      wrap_up;
    end
    @(posedge core_clk);
  endtask
  task automatic t_div;
    int p;
    int n;
    for (int c = 0; c < 8; c++) begin
      wr(2'h0, 8'(c << 4));
      wr(2'h1, c == 3 ? 8'h04 : 8'h40);
      per(c == 3, p);
      chk("period", 10'(4 << c), 10'(p));
    end
    wr(2'h1, 8'h00);
    n = 0;
    repeat (520) begin
      @(posedge core_clk);
      n += latch_set;
    end
    chk("idle", 10'h000, 10'(n));
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    t_regs;
    t_soft;
    t_src;
    t_div;
    wrap_up;
  end
endmodule
`default_nettype wire
